// ==== shared/asram_pkg.sv ====
/*
 package for the host-side controller of a 4k x 4 asynchronous sram.
 assumes a 25 MHz system clock; the memory itself has no clock.
*/
`default_nettype none
package asram_pkg;
   // ****************************************
   // geometry
   // ****************************************
   localparam int ASRAM_ADDR_W = 12;
   localparam int ASRAM_DATA_W = 4;
   localparam int ASRAM_DEPTH = 4096;
   // ****************************************
   // timing
   // ****************************************
   localparam int ASRAM_CLK_NS = 40;
   // least write overlap, slowest grade
   localparam int ASRAM_WR_PULSE_NS = 25;
   // longest read access, slowest grade
   localparam int ASRAM_RD_ACC_NS = 35;
   // longest powerdown_delay, slowest grade
   localparam int ASRAM_PWRDN_NS = 35;
   localparam int ASRAM_WR_CYC =
      (ASRAM_WR_PULSE_NS + ASRAM_CLK_NS - 1) / ASRAM_CLK_NS;
   // access rounds up: data are sampled only after the access time
   localparam int ASRAM_RD_CYC =
      (ASRAM_RD_ACC_NS + ASRAM_CLK_NS - 1) / ASRAM_CLK_NS + 1;
   localparam int ASRAM_PWRDN_CYC_RAW = ASRAM_PWRDN_NS / ASRAM_CLK_NS;
   localparam int ASRAM_PWRDN_CYC =
      (ASRAM_PWRDN_CYC_RAW < 1) ? 1 : ASRAM_PWRDN_CYC_RAW;
   localparam logic [3:0] ASRAM_CNT_ZERO = 4'h0;
   localparam logic [3:0] ASRAM_CNT_ONE = 4'h1;
   typedef enum logic [2:0] {
      ASRAM_IDLE,
      ASRAM_SETUP,
      ASRAM_WRITE,
      ASRAM_READ,
      ASRAM_RECOVER
   } asram_state_t;
endpackage : asram_pkg
`default_nettype wire

// ==== shared/asram_pin_if.sv ====
/*
 internal bundle carrying the memory pin values between controller and
 its pin sequencer. assumes a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface asram_pin_if #(
   parameter int AW = 12,
   parameter int DW = 4
);
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic cs_b;
   logic we_b;
   logic start;
   logic is_write;
   logic done;
   modport ctrl (output start, output is_write, input done,
                 input addr, input wdata, input cs_b, input we_b);
   modport seq (input start, input is_write, output done,
                output addr, output wdata, output cs_b, output we_b);
endinterface : asram_pin_if
`default_nettype wire

// ==== src/asram_pin_seq.sv ====
/*
 pin sequencer: turns one start pulse into a strobe pattern on the
 memory pins. captures address and data from its parent at the start
 pulse and holds them on the pins for the whole access.
*/
`timescale 1ns/1ps
`default_nettype none
module asram_pin_seq
   import asram_pkg::*;
#(
   parameter int AW = ASRAM_ADDR_W,
   parameter int DW = ASRAM_DATA_W
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [DW-1:0] wdata_i,
   asram_pin_if.seq pins
);
   // ****************************************
   // sequencer state
   // ****************************************
   asram_state_t state;
   asram_state_t next_state;
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic [AW-1:0] addr;
   logic [AW-1:0] next_addr;
   logic [DW-1:0] wdata;
   logic [DW-1:0] next_wdata;
   logic cs_b;
   logic next_cs_b;
   logic we_b;
   logic next_we_b;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_addr = addr;
      next_wdata = wdata;
      unique case (state)
         ASRAM_IDLE: begin
            // address only moves while deselected
            if (pins.start) begin
               next_addr = addr_i;
               next_wdata = wdata_i;
               next_state = ASRAM_SETUP;
            end
         end
         ASRAM_SETUP: begin
            // address has stood one cycle before select falls
            next_state = pins.is_write ? ASRAM_WRITE : ASRAM_READ;
            next_cnt = pins.is_write ? 4'(ASRAM_WR_CYC) : 4'(ASRAM_RD_CYC);
         end
         ASRAM_WRITE, ASRAM_READ: begin
            if (cnt == ASRAM_CNT_ONE) begin
               next_state = ASRAM_RECOVER;
            end else begin
               next_cnt = cnt - ASRAM_CNT_ONE;
            end
         end
         ASRAM_RECOVER: begin
            next_state = ASRAM_IDLE;
            next_cnt = ASRAM_CNT_ZERO;
         end
      endcase
      // strobes leave flip-flops: a decode of the state code could
      // glitch through the write code between read and recover
      next_cs_b = !(next_state == ASRAM_WRITE
         || next_state == ASRAM_READ);
      next_we_b = (next_state != ASRAM_WRITE);
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= ASRAM_IDLE;
         cnt <= ASRAM_CNT_ZERO;
         addr <= '0;
         wdata <= '0;
         cs_b <= 1'b1;
         we_b <= 1'b1;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         addr <= next_addr;
         wdata <= next_wdata;
         cs_b <= next_cs_b;
         we_b <= next_we_b;
      end
   end

   // ****************************************
   // pin drive
   // ****************************************
   // on writes both strobes fall and rise together: this keeps the device output
   // quiet across writes, at the cost of no transparent readback
   assign pins.cs_b = cs_b;
   assign pins.we_b = we_b;
   assign pins.addr = addr;
   assign pins.wdata = wdata;
   assign pins.done = (state == ASRAM_RECOVER);

   default clocking seq_cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   a_we_only_when_cs: assert property (
      !pins.we_b |-> !pins.cs_b)
      else $error("write strobe low while deselected");
   a_addr_stable_sel: assert property (
      !pins.cs_b |-> $stable(pins.addr))
      else $error("address moved while selected");
   a_write_pulse_len: assert property (
      $fell(pins.we_b) |-> !pins.we_b [*1] ##1 (pins.we_b && pins.cs_b))
      else $error("write overlap length wrong");
   a_read_we_high: assert property (
      state == ASRAM_READ |-> pins.we_b)
      else $error("write strobe low during read");
   a_setup_before_cs: assert property (
      $fell(pins.cs_b) |-> $past(state) == ASRAM_SETUP)
      else $error("select fell without address setup");
endmodule : asram_pin_seq
`default_nettype wire

// ==== src/asram_host.sv ====
/*
 host controller for a 4k x 4 asynchronous sram with separate data in
 and data out pins. assumes the memory output is valid on dout_i within
 the access time and that dout_i is sampled synchronously.
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - writing happens only while select and write strobe are both low
// - write ends at whichever strobe rises first
// - write strobe stays high through every read
// - address is valid before or as select falls
// - address changes only while select or write strobe is high
module asram_host
   import asram_pkg::*;
#(
   parameter int AW = ASRAM_ADDR_W,
   parameter int DW = ASRAM_DATA_W
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic req_i,
   input wire logic req_write_i,
   input wire logic [AW-1:0] req_addr_i,
   input wire logic [DW-1:0] req_wdata_i,
   output logic ready_o,
   output logic rdata_valid_o,
   output logic [DW-1:0] rdata_o,
   output logic wr_done_o,
   output logic mem_awake_o,
   output logic [AW-1:0] mem_addr_o,
   output logic [DW-1:0] mem_din_o,
   output logic mem_cs_b_o,
   output logic mem_we_b_o,
   input wire logic [DW-1:0] mem_dout_i
);
   // ****************************************
   // elaboration checks
   // ****************************************
   // timing counts are worked out for this one geometry only
   if (AW != ASRAM_ADDR_W || DW != ASRAM_DATA_W) begin : g_size_check
      $error("only a 4096 x 4 memory is served");
   end

   asram_pin_if #(.AW(AW), .DW(DW)) pins ();

   asram_pin_seq #(.AW(AW), .DW(DW)) u_seq (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .addr_i(req_addr_i),
      .wdata_i(req_wdata_i),
      .pins(pins)
   );

   // ****************************************
   // request tracking
   // ****************************************
   logic busy;
   logic next_busy;
   logic wr;
   logic next_wr;
   logic [DW-1:0] rdata;
   logic [DW-1:0] next_rdata;
   logic rvalid;
   logic next_rvalid;
   logic wdone;
   logic next_wdone;

   assign pins.start = req_i && !busy;
   assign pins.is_write = busy ? wr : req_write_i;

   always_comb begin
      next_busy = busy;
      next_wr = wr;
      next_rdata = rdata;
      next_rvalid = 1'b0;
      next_wdone = 1'b0;
      if (pins.start) begin
         next_busy = 1'b1;
         next_wr = req_write_i;
      end
      if (pins.done) begin
         next_busy = 1'b0;
         next_rvalid = !wr;
         next_wdone = wr;
      end
      // sample in every selected read cycle; the last one, after the access time, is kept
      if (busy && !wr && !pins.cs_b) begin
         next_rdata = mem_dout_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy <= 1'b0;
         wr <= 1'b0;
         rdata <= '0;
         rvalid <= 1'b0;
         wdone <= 1'b0;
      end else begin
         busy <= next_busy;
         wr <= next_wr;
         rdata <= next_rdata;
         rvalid <= next_rvalid;
         wdone <= next_wdone;
      end
   end

   // ****************************************
   // power tracking
   // ****************************************
   // a mirror of the memory's own power state; the delay is shorter
   // than a clock so the memory is only awake while it is being used
   logic [3:0] pwr_cnt;
   logic [3:0] next_pwr_cnt;
   logic cs_q;
   logic next_cs_q;
   logic wake;

   assign wake = (!pins.cs_b && cs_q)
      || (!pins.we_b && !pins.cs_b);

   always_comb begin
      next_cs_q = pins.cs_b;
      next_pwr_cnt = pwr_cnt;
      if (wake) begin
         next_pwr_cnt = 4'(ASRAM_PWRDN_CYC);
      end else if (pwr_cnt != ASRAM_CNT_ZERO) begin
         next_pwr_cnt = pwr_cnt - ASRAM_CNT_ONE;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pwr_cnt <= ASRAM_CNT_ZERO;
         cs_q <= 1'b1;
      end else begin
         pwr_cnt <= next_pwr_cnt;
         cs_q <= next_cs_q;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // on writes the strobes fall and rise together so the output stays floating in
   // both variants; the host never reads during a write
   assign ready_o = !busy;
   assign rdata_valid_o = rvalid;
   assign rdata_o = rdata;
   assign wr_done_o = wdone;
   assign mem_awake_o = (pwr_cnt != ASRAM_CNT_ZERO);
   assign mem_addr_o = pins.addr;
   assign mem_din_o = pins.wdata;
   assign mem_cs_b_o = pins.cs_b;
   assign mem_we_b_o = pins.we_b;

   // ****************************************
   // rule checks
   // ****************************************
   // answer latencies lean on the package cycle counts; a new clock
   // rate changes them here as well
   default clocking host_cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   a_strobes_together: assert property (
      $fell(mem_we_b_o) |-> $fell(mem_cs_b_o))
      else $error("write strobe fell apart from select");
   a_write_end_sync: assert property (
      $rose(mem_we_b_o) |-> $rose(mem_cs_b_o))
      else $error("write strobe rose apart from select");
   a_read_answer: assert property (
      ready_o && req_i && !req_write_i |-> ##5 rdata_valid_o)
      else $error("read answer not on time");
   a_write_answer: assert property (
      ready_o && req_i && req_write_i |-> ##4 wr_done_o)
      else $error("write answer not on time");
   a_power_down: assert property (
      mem_cs_b_o && $past(mem_cs_b_o) |-> ##1 !mem_awake_o)
      else $error("memory tracked awake while idle");
   a_wake_on_select: assert property (
      $fell(mem_cs_b_o) |=> mem_awake_o)
      else $error("select fall did not wake memory");
   a_wake_on_write: assert property (
      !mem_we_b_o |=> mem_awake_o)
      else $error("write strobe did not wake memory");
   a_wr_pulse_once: assert property (
      wr_done_o |=> !wr_done_o)
      else $error("write done longer than one cycle");
   a_rd_pulse_once: assert property (
      rdata_valid_o |=> !rdata_valid_o)
      else $error("read valid longer than one cycle");
   a_rdata_held: assert property (
      mem_cs_b_o |=> $stable(rdata_o))
      else $error("read data moved while deselected");
   a_rdata_taken: assert property (
      rdata_valid_o |-> rdata_o == $past(mem_dout_i, 2))
      else $error("read data not the last selected sample");
   a_din_held: assert property (
      !mem_we_b_o |-> $stable(mem_din_o))
      else $error("write data moved during the overlap");
   a_idle_deselect: assert property (
      ready_o |-> mem_cs_b_o && mem_we_b_o)
      else $error("memory selected while idle");

   // ****************************************
   // cover points
   // ****************************************
   // a refused request and a drop to low power are the corner cases
   c_read: cover property (rdata_valid_o);
   c_write: cover property (wr_done_o);
   c_back_to_back: cover property (wr_done_o ##1 (req_i && ready_o));
   c_refused: cover property (req_i && !ready_o);
   c_sleep: cover property ($fell(mem_awake_o));
endmodule : asram_host
`default_nettype wire

// ==== tb/asram_mem_model.sv ====
/*
 behavioural model of the 4k x 4 asynchronous sram at the host's pins.
 assumes the host drives every pin from registers on one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module asram_mem_model
   import asram_pkg::*;
#(
   parameter bit TRANSP = 1'b0
) (
   input wire logic slow_i,
   input wire logic [ASRAM_ADDR_W-1:0] addr_i,
   input wire logic [ASRAM_DATA_W-1:0] din_i,
   input wire logic cs_b_i,
   input wire logic we_b_i,
   output logic [ASRAM_DATA_W-1:0] dout_o,
   output logic awake_o,
   output logic [7:0] viol_o
);
   logic [ASRAM_DATA_W-1:0] mem [ASRAM_DEPTH];
   logic [ASRAM_DATA_W-1:0] flt = 4'h5;
   logic valid = 1'b0;
   logic wfirst = 1'b0;
   realtime t_wake = 0.0;
   initial awake_o = 1'b0;
   initial viol_o = 8'h00;
   task automatic wake();
      awake_o = 1'b1;
      t_wake = $realtime;
   endtask : wake
   // a released line shows a moving pattern, never the last word
   always #17 flt = ~flt;
   // output turns on late, turns off at once
   always @(addr_i, cs_b_i) begin
      valid = 1'b0;
      valid <= #(slow_i ? ASRAM_RD_ACC_NS : 3) 1'b1;
   end
   always @(negedge cs_b_i) wfirst = !we_b_i;
   always @* begin
      if (!cs_b_i && !we_b_i) mem[addr_i] = din_i;
   end
   always @* begin
      if (!cs_b_i && we_b_i && valid) dout_o = mem[addr_i];
      else if (TRANSP && !cs_b_i && !we_b_i && !wfirst) dout_o = din_i;
      else dout_o = flt;
   end
   always @(negedge cs_b_i, negedge we_b_i, addr_i) begin
      if (!cs_b_i) wake();
   end
   always @(din_i) begin
      if (!cs_b_i && !we_b_i) wake();
   end
   always #1 begin
      if (awake_o && $realtime - t_wake >= ASRAM_PWRDN_NS) awake_o = 1'b0;
   end
   // a select rise in the same step as the address is no fault
   always @(addr_i) begin
      #0.1;
      if (!cs_b_i) viol_o = viol_o + 8'h01;
   end
endmodule : asram_mem_model
`default_nettype wire

// ==== tb/asram_host_bench.sv ====
/*
 self-checking bench for asram_host.
 assumes the sram model in tb/ on the memory pins.
*/
`timescale 1ns/1ps
`default_nettype none
module asram_host_bench
   import asram_pkg::*;
();
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic req = 1'b0;
   logic wr_q = 1'b0;
   logic slow = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [3:0] wdat = 4'h0;
   logic rdy, rvld, wdone, awake, mawake, cs_b, we_b;
   logic [3:0] rdat, din, dout;
   logic [11:0] maddr;
   logic [7:0] viol;
   int n_mismatch = 0;
   int n_checks = 0;
   always #20 clk = ~clk;
   asram_host dut (.clk_i(clk), .rst_b_i(rst_b), .req_i(req),
      .req_write_i(wr_q), .req_addr_i(addr), .req_wdata_i(wdat),
      .ready_o(rdy), .rdata_valid_o(rvld), .rdata_o(rdat),
      .wr_done_o(wdone), .mem_awake_o(awake), .mem_addr_o(maddr),
      .mem_din_o(din), .mem_cs_b_o(cs_b), .mem_we_b_o(we_b),
      .mem_dout_i(dout));
   asram_mem_model mem (.slow_i(slow), .addr_i(maddr), .din_i(din),
      .cs_b_i(cs_b), .we_b_i(we_b), .dout_o(dout), .awake_o(mawake),
      .viol_o(viol));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // one access; hold keeps req up, aimed elsewhere, while busy
   task automatic op(input logic w, input logic [11:0] a,
                     input logic [3:0] d, input logic hold);
      int t_done = 0;
      int n_sel = 0;
      int n_both = 0;
      int n_bad = 0;
      int seen = 0;
      int seen_m = 0;
      chk("ready", 1, rdy);
      req = 1'b1;
      wr_q = w;
      addr = a;
      wdat = d;
      for (int k = 1; k <= 10 && t_done == 0; k++) begin
         @(negedge clk);
         if (k == 1 && hold) addr = ~a;
         if (k == (hold ? 3 : 1)) req = 1'b0;
         n_sel += (cs_b === 1'b0);
         n_both += (cs_b === 1'b0 && we_b === 1'b0);
         if (w ? (cs_b === 1'b0 && we_b !== 1'b0) : we_b !== 1'b1) n_bad++;
         if (cs_b === 1'b0 && (maddr !== a || (w && din !== d))) n_bad++;
         if (awake === 1'b1) seen = 1;
         if (mawake === 1'b1) seen_m = 1;
         if ((w ? wdone : rvld) === 1'b1) t_done = k;
      end
      if (t_done == 0) begin
         n_mismatch++;
         $display("mismatch done expected pulse seen none");
         give_verdict();
      end
      chk("latency", w ? 4 : 5, t_done);
      chk("select", w ? ASRAM_WR_CYC : ASRAM_RD_CYC, n_sel);
      chk("overlap", w ? ASRAM_WR_CYC : 0, n_both);
      chk("pins", 0, n_bad);
      chk("awake", 1, seen);
      chk("model awake", 1, seen_m);
      if (!w) chk("rdata", d, rdat);
   endtask : op
   // every data code, at sixteen addresses 000 to fff spaced 111 apart, back to back
   task automatic t_walk();
      for (int i = 0; i < 16; i++) op(1'b1, 12'(i * 273), 4'(i), 1'b0);
      for (int i = 0; i < 16; i++) op(1'b0, 12'(i * 273), 4'(i), 1'b0);
      $display("test walk done");
   endtask : t_walk
   // a request made while busy is dropped without trace
   task automatic t_refuse();
      op(1'b1, 12'hf0f, 4'h3, 1'b0);
      op(1'b1, 12'h0f0, 4'hc, 1'b1);
      op(1'b0, 12'hf0f, 4'h3, 1'b1);
      op(1'b0, 12'h0f0, 4'hc, 1'b0);
      $display("test refuse done");
   endtask : t_refuse
   // slow memory: data only after the full access time
   task automatic t_slow();
      slow = 1'b1;
      op(1'b0, 12'hfff, 4'hf, 1'b0);
      op(1'b0, 12'h000, 4'h0, 1'b0);
      slow = 1'b0;
      repeat (3) @(negedge clk);
      chk("idle awake", 0, awake);
      chk("model idle", 0, mawake);
      $display("test slow done");
   endtask : t_slow
   // reset in mid-write must release the strobes at once
   task automatic t_rerun();
      req = 1'b1;
      wr_q = 1'b1;
      addr = 12'h111;
      wdat = 4'h9;
      repeat (2) @(negedge clk);
      req = 1'b0;
      rst_b = 1'b0;
      #1;
      chk("abort select", 1, cs_b);
      chk("abort strobe", 1, we_b);
      @(negedge clk);
      rst_b = 1'b1;
      op(1'b0, 12'h222, 4'h2, 1'b0);
      $display("test rerun done");
   endtask : t_rerun
   initial begin
      repeat (6) @(negedge clk);
      chk("reset ready", 1, rdy);
      chk("reset select", 1, cs_b);
      chk("reset strobe", 1, we_b);
      chk("reset awake", 0, awake);
      chk("reset rdata", 0, rdat);
      $display("test reset done");
      rst_b = 1'b1;
      t_walk();
      t_refuse();
      t_slow();
      t_rerun();
      chk("model faults", 0, viol);
      give_verdict();
   end
endmodule : asram_host_bench
`default_nettype wire
